// ==== core/csr_pkg.sv ====
// Package of constants, types and state layouts for the conversion sequencer.
package csr_pkg;

	// ----------------------------------------------------------------
	// Command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_NULL = 8'h00;
	localparam logic [7:0] CMD_SINGLE = 8'hC0;
	localparam logic [7:0] CMD_CONT = 8'hA0;
	localparam logic [7:0] CMD_RD_DATA = 8'h96;
	localparam logic [7:0] CMD_RD_CFG = 8'h9E;
	localparam logic [7:0] CMD_RD_OFFS = 8'h92;
	localparam logic [7:0] CMD_RD_GAIN = 8'h94;

	// ----------------------------------------------------------------
	// Sizes, counts and field positions
	// ----------------------------------------------------------------
	localparam int CONV_CYCLES_DEF = 2180;
	localparam int CNT_W = 16;
	localparam int RAW_W = 18;
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [4:0] WORD_LAST_BIT = 5'h17;
	localparam int CFG_DONE_POS = 3;
	localparam int CFG_FLAG_POS = 5;
	localparam logic [3:0] TRAIL_ONES = 4'hF;
	localparam logic [1:0] TRAIL_ZEROS = 2'h0;
	localparam logic [23:0] WORD_ZERO = 24'h000000;

	// ----------------------------------------------------------------
	// Saturation limits and codes
	// ----------------------------------------------------------------
	localparam logic signed [17:0] UNI_MAX = 18'sh0FFFF;
	localparam logic signed [17:0] UNI_MIN = 18'sh00000;
	localparam logic signed [17:0] BIP_MAX = 18'sh07FFF;
	localparam logic signed [17:0] BIP_MIN = 18'sh38000;
	localparam logic [15:0] UNI_SAT_HI = 16'hFFFF;
	localparam logic [15:0] UNI_SAT_LO = 16'h0000;
	localparam logic [15:0] BIP_SAT_HI = 16'h7FFF;
	localparam logic [15:0] BIP_SAT_LO = 16'h8000;

	// ----------------------------------------------------------------
	// Types and reset values
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSR_IDLE = 2'b00,
		CSR_SINGLE = 2'b01,
		CSR_CONT = 2'b10
	} csr_conv_e;

	typedef struct packed {
		csr_conv_e st;
		logic [CNT_W-1:0] cnt;
		logic done;
		logic ready;
		logic over;
		logic osc;
		logic [23:0] res;
		logic [1:0] cs_sync;
		logic [2:0] tog_sync;
		logic [1:0] act_sync;
		logic [1:0] bit_sync;
		logic serial_out_pin;
		logic oe;
	} csr_core_s;

	typedef struct packed {
		logic in_data;
		logic [4:0] bit_cnt;
		logic [6:0] rx;
		logic [7:0] cmd;
		logic tog;
		logic [23:0] word;
		logic [1:0] rdy_sync;
		logic [1:0] flg_sync;
		logic [1:0] done_sync;
	} csr_link_s;

	typedef struct packed {
		logic act;
		logic bit_val;
	} csr_tx_s;

	localparam csr_core_s CORE_RST = '0;
	localparam csr_link_s LINK_RST = '0;
	localparam csr_tx_s TX_RST = '0;

endpackage

// ==== core/csr_core.sv ====
// Conversion sequencer with serial command port and result readout.
//
// Function
// - Command C0 runs exactly one conversion.
// - Done flag sets when conversion completes.
// - Command 96 shifts out the result word when flag mode is off.
// - Data, gain, offset reads clear done flag.
// - Repeated single command restarts the conversion.
// - Flag mode drives serial out low when ready.
// - Null byte clears flag, MSB follows.
// - Twenty-four clocks shift the result out.
// - Data mode ignores input until word read.
// - Command A0 starts repeated flagged conversions.
// - Unread flag rises one cycle before next.
// - Valid non-null command other than A0 leaves continuous mode.
// - Continuous command restarts a running conversion.
// - Continuous mode only with flag mode set.
// - Word: data, four ones, two zeros, flags.
// - Over-range flag tracks each saturated result.
// - Oscillation flag follows the modulator detector.
// - Unipolar binary, bipolar two's complement, saturating.
`timescale 1ns/100ps
module csr_core #(
	parameter int CONV_CYCLES = csr_pkg::CONV_CYCLES_DEF
) (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	// Serial port pins
	input wire logic cs_n_i,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	// Configuration
	input wire logic port_flag_mode_i,
	input wire logic unipolar_i,
	// Modulator side
	input wire logic signed [csr_pkg::RAW_W-1:0] adc_raw_i,
	input wire logic adc_osc_i,
	// Status
	output logic done_flag_o,
	output logic over_range_flag_o,
	output logic oscillation_detect_flag_o
);
	import csr_pkg::*;

	localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CONV_CYCLES - 1);
	localparam logic [CNT_W-1:0] PRE_CNT = CNT_W'(CONV_CYCLES - 2);

	csr_core_s c_reg;
	csr_core_s c_next;
	csr_link_s l_reg;
	csr_link_s l_next;
	csr_tx_s t_reg;
	csr_tx_s t_next;
	logic cmd_evt;
	logic conv_done;
	logic restart;
	logic rd_clr;
	logic valid_exit;
	logic [15:0] code;
	logic over;
	logic [7:0] rx_byte;
	logic [23:0] cfg_word;

	// ----------------------------------------------------------------
	// Conversion engine on the master clock
	// ----------------------------------------------------------------
	always_comb begin
		c_next = c_reg;
		code = UNI_SAT_LO;
		over = 1'b0;
		cmd_evt = c_reg.tog_sync[2] ^ c_reg.tog_sync[1];
		conv_done = (c_reg.st != CSR_IDLE) && (c_reg.cnt == LAST_CNT);
		rd_clr = cmd_evt && (l_reg.cmd == CMD_RD_DATA ||
			l_reg.cmd == CMD_RD_OFFS || l_reg.cmd == CMD_RD_GAIN);
		valid_exit = rd_clr || (cmd_evt && l_reg.cmd == CMD_RD_CFG);
		restart = cmd_evt && (l_reg.cmd == CMD_SINGLE ||
			(l_reg.cmd == CMD_CONT && port_flag_mode_i));
		c_next.cs_sync = {c_reg.cs_sync[0], cs_n_i};
		c_next.tog_sync = {c_reg.tog_sync[1:0], l_reg.tog};
		c_next.act_sync = {c_reg.act_sync[0], t_reg.act};
		c_next.bit_sync = {c_reg.bit_sync[0], t_reg.bit_val};
		// Saturate the raw filter output into the 16-bit code.
		if (unipolar_i) begin
			code = adc_raw_i[15:0];
			if (adc_raw_i > UNI_MAX) begin
				code = UNI_SAT_HI;
				over = 1'b1;
			end else if (adc_raw_i < UNI_MIN) begin
				code = UNI_SAT_LO;
				over = 1'b1;
			end
		end else begin
			code = adc_raw_i[15:0];
			if (adc_raw_i > BIP_MAX) begin
				code = BIP_SAT_HI;
				over = 1'b1;
			end else if (adc_raw_i < BIP_MIN) begin
				code = BIP_SAT_LO;
				over = 1'b1;
			end
		end
		if (c_reg.st != CSR_IDLE) begin
			c_next.cnt = c_reg.cnt + 1'b1;
		end
		if (rd_clr) begin
			c_next.done = 1'b0;
		end
		if (cmd_evt && l_reg.cmd == CMD_NULL && port_flag_mode_i) begin
			c_next.ready = 1'b0;
		end
		if (c_reg.st == CSR_CONT && c_reg.ready && c_reg.cnt == PRE_CNT) begin
			c_next.ready = 1'b0;
		end
		if (c_reg.st == CSR_CONT && valid_exit) begin
			c_next.st = CSR_IDLE;
			c_next.cnt = '0;
			c_next.ready = 1'b0;
		end
		// A restart abandons a result due in the same cycle.
		if (conv_done && !restart) begin
			c_next.res = {code, TRAIL_ONES, TRAIL_ZEROS, adc_osc_i, over};
			c_next.over = over;
			c_next.osc = adc_osc_i;
			c_next.done = 1'b1;
			c_next.ready = port_flag_mode_i;
			c_next.cnt = '0;
			if (c_reg.st == CSR_SINGLE) begin
				c_next.st = CSR_IDLE;
			end
		end
		if (restart) begin
			c_next.cnt = '0;
			if (l_reg.cmd == CMD_SINGLE) begin
				c_next.st = CSR_SINGLE;
			end else begin
				c_next.st = CSR_CONT;
			end
		end
		c_next.oe = !c_reg.cs_sync[1];
		if (c_reg.act_sync[1]) begin
			c_next.serial_out_pin = c_reg.bit_sync[1];
		end else if (port_flag_mode_i) begin
			c_next.serial_out_pin = !c_reg.ready;
		end else begin
			c_next.serial_out_pin = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			c_reg <= CORE_RST;
		end else begin
			c_reg <= c_next;
		end
	end

	// ----------------------------------------------------------------
	// Link logic on the serial clock
	// ----------------------------------------------------------------
	// The result word is read here without a handshake: it only changes
	// when a conversion completes, which the host must not overlap.
	always_comb begin
		l_next = l_reg;
		rx_byte = {l_reg.rx, serial_in_pin_i};
		cfg_word = WORD_ZERO;
		cfg_word[CFG_DONE_POS] = l_reg.done_sync[1];
		cfg_word[CFG_FLAG_POS] = l_reg.flg_sync[1];
		l_next.rdy_sync = {l_reg.rdy_sync[0], c_reg.ready};
		l_next.flg_sync = {l_reg.flg_sync[0], port_flag_mode_i};
		l_next.done_sync = {l_reg.done_sync[0], c_reg.done};
		if (!cs_n_i) begin
			if (l_reg.in_data) begin
				if (l_reg.bit_cnt == WORD_LAST_BIT) begin
					l_next.in_data = 1'b0;
					l_next.bit_cnt = '0;
				end else begin
					l_next.bit_cnt = l_reg.bit_cnt + 1'b1;
				end
			end else begin
				l_next.rx = rx_byte[6:0];
				if (l_reg.bit_cnt == CMD_LAST_BIT) begin
					l_next.bit_cnt = '0;
					l_next.cmd = rx_byte;
					l_next.tog = !l_reg.tog;
					if (rx_byte == CMD_NULL && l_reg.flg_sync[1] &&
						l_reg.rdy_sync[1]) begin
						l_next.in_data = 1'b1;
						l_next.word = c_reg.res;
					end else if (rx_byte == CMD_RD_DATA && !l_reg.flg_sync[1]) begin
						l_next.in_data = 1'b1;
						l_next.word = c_reg.res;
					end else if (rx_byte == CMD_RD_CFG) begin
						l_next.in_data = 1'b1;
						l_next.word = cfg_word;
					end else if (rx_byte == CMD_RD_OFFS || rx_byte == CMD_RD_GAIN) begin
						l_next.in_data = 1'b1;
						l_next.word = WORD_ZERO;
					end
				end else begin
					l_next.bit_cnt = l_reg.bit_cnt + 1'b1;
				end
			end
		end
		t_next.act = l_reg.in_data && !cs_n_i;
		t_next.bit_val = l_reg.word[WORD_LAST_BIT - l_reg.bit_cnt];
	end

	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			l_reg <= LINK_RST;
		end else begin
			l_reg <= l_next;
		end
	end

	// Output bits change on the falling edge so the host samples mid-bit.
	always_ff @(negedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t_reg <= TX_RST;
		end else begin
			t_reg <= t_next;
		end
	end

	assign serial_out_pin_o = c_reg.serial_out_pin;
	assign serial_out_pin_oe_o = c_reg.oe;
	assign done_flag_o = c_reg.done;
	assign over_range_flag_o = c_reg.over;
	assign oscillation_detect_flag_o = c_reg.osc;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	done_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart |=> done_flag_o)
		else $error("done flag not set after conversion");
	read_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_clr && !conv_done |=> !done_flag_o)
		else $error("done flag not cleared by read");
	cfg_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_evt && l_reg.cmd == CMD_RD_CFG && done_flag_o |=> done_flag_o)
		else $error("config read changed done flag");
	single_restart_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_evt && l_reg.cmd == CMD_SINGLE |=>
		c_reg.st == CSR_SINGLE && c_reg.cnt == '0 ##1 c_reg.cnt == 16'h0001)
		else $error("single command did not restart");
	single_stop_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart && c_reg.st == CSR_SINGLE |=> c_reg.st == CSR_IDLE)
		else $error("single conversion did not stop");
	flag_low_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		port_flag_mode_i && $stable(port_flag_mode_i) && c_reg.ready &&
		!c_reg.act_sync[1] |=> !serial_out_pin_o)
		else $error("flag not driven low when ready");
	early_rise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		c_reg.st == CSR_CONT && c_reg.ready && c_reg.cnt == PRE_CNT &&
		!cmd_evt && port_flag_mode_i |=> !c_reg.ready ##1 c_reg.ready)
		else $error("flag did not rise one cycle before result");
	cont_exit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		c_reg.st == CSR_CONT && valid_exit && !restart |=> c_reg.st == CSR_IDLE)
		else $error("continuous mode not left on command");
	cont_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_evt && l_reg.cmd == CMD_CONT && !port_flag_mode_i &&
		c_reg.st == CSR_IDLE |=> c_reg.st == CSR_IDLE)
		else $error("continuous mode entered without flag mode");
	word_format_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart |=> c_reg.res[7:2] == 6'b111100 &&
		c_reg.res[0] == over_range_flag_o && c_reg.res[1] == oscillation_detect_flag_o)
		else $error("result word layout wrong");
	uni_sat_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart && unipolar_i && adc_raw_i < UNI_MIN |=>
		c_reg.res[23:8] == UNI_SAT_LO && over_range_flag_o)
		else $error("unipolar underrange not saturated");
	data_len_a: assert property (@(posedge sclk_i) disable iff (!rstn_i)
		l_reg.in_data && l_reg.bit_cnt == WORD_LAST_BIT && !cs_n_i |=> !l_reg.in_data)
		else $error("data mode did not end after word");
	data_hold_a: assert property (@(posedge sclk_i) disable iff (!rstn_i)
		l_reg.in_data |=> $stable(l_reg.cmd))
		else $error("command taken during data mode");

	// Clock domain of the conversion engine again.
	null_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cmd_evt && l_reg.cmd == CMD_NULL && port_flag_mode_i && !conv_done
		|=> !c_reg.ready)
		else $error("null command did not clear the flag");
	cont_ready_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart && c_reg.st == CSR_CONT && port_flag_mode_i
		|=> c_reg.ready)
		else $error("continuous result not flagged");
	over_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart && !over |=> !over_range_flag_o)
		else $error("over-range flag not cleared");
	osc_track_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart |=>
		oscillation_detect_flag_o == $past(adc_osc_i))
		else $error("oscillation flag not taken from detector");
	bip_sat_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		conv_done && !restart && !unipolar_i && adc_raw_i > BIP_MAX |=>
		c_reg.res[23:8] == BIP_SAT_HI && over_range_flag_o)
		else $error("bipolar overrange not saturated");

endmodule

// ==== verification/csr_host.sv ====
// Host model driving the four-wire serial port of the sequencer.
`timescale 1ns/100ps
module csr_host (
	// Serial port to the device
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	// Resolved serial out line
	output logic line_o
);
	logic last_n;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
		last_n = 1'b0;
	end
	// The line has no pull, so a released line shows the inverse bit.
	always @(sdo_i or sdo_oe_i) begin
		if (sdo_oe_i) begin
			last_n = ~sdo_i;
		end
	end
	assign line_o = sdo_oe_i ? sdo_i : last_n;
	// Chip select moves only while the serial clock is low.
	task automatic frame(input logic on);
		#80;
		cs_n_o = ~on;
		#80;
	endtask
	// The clock stands still between transfers.
	task automatic xfer(input logic [7:0] cmd, input logic rd,
		output logic [23:0] w);
		w = 24'h000000;
		for (int i = 7; i >= 0; i--) begin
			sdi_o = cmd[i];
			#80 sclk_o = 1'b1;
			#80 sclk_o = 1'b0;
		end
		sdi_o = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			if (rd) begin
				#80 sclk_o = 1'b1;
				w[i] = line_o;
				#80 sclk_o = 1'b0;
			end
		end
	endtask
endmodule

// ==== verification/conversion_sequencer_readout_tb.sv ====
// Self-checking bench for the conversion sequencer.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	$display("Error %s exp %0h got %0h", n, e, g); err_count++; end end
module conversion_sequencer_readout_tb;
	import csr_pkg::*;
	localparam int CONV = 2000;
	logic clk_i, rstn_i, sclk, cs_n, serial_in_pin, serial_out_pin, sdo_oe, line;
	logic pfm, uni, osc, done, ovr, oscf;
	logic signed [17:0] raw;
	logic [23:0] w;
	int err_count, samples_checked;
	always #2.5 clk_i = ~clk_i;
	csr_host h (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(serial_in_pin), .sdo_i(serial_out_pin),
		.sdo_oe_i(sdo_oe), .line_o(line));
	csr_core #(.CONV_CYCLES(CONV)) DUT (.clk_i(clk_i), .rstn_i(rstn_i),
		.sclk_i(sclk), .cs_n_i(cs_n), .serial_in_pin_i(serial_in_pin),
		.serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(sdo_oe),
		.port_flag_mode_i(pfm), .unipolar_i(uni), .adc_raw_i(raw),
		.adc_osc_i(osc), .done_flag_o(done), .over_range_flag_o(ovr),
		.oscillation_detect_flag_o(oscf));
	task automatic results();
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wait_for(input logic sel, input logic lvl, input int lim);
		int n;
		n = 0;
		while ((sel ? line : done) !== lvl) begin
			@(posedge clk_i);
			n++;
			if (n > lim) begin
				err_count++;
				results();
			end
		end
	endtask
	task automatic set_in(input logic [17:0] r, input logic u, o, p);
		@(posedge clk_i);
		raw <= r;
		uni <= u;
		osc <= o;
		pfm <= p;
	endtask
	task automatic conv_read(input logic [17:0] r, input logic u, o,
		input logic [7:0] cmd, input logic [23:0] e);
		set_in(r, u, o, 1'b0);
		h.frame(1'b1);
		h.xfer(CMD_SINGLE, 1'b0, w);
		wait_for(1'b0, 1'b1, CONV + 300);
		h.xfer(CMD_RD_CFG, 1'b1, w);
		`CHK("cfg", 24'h000008, w)
		`CHK("done kept", 1'b1, done)
		h.xfer(cmd, 1'b1, w);
		h.frame(1'b0);
		repeat (8) @(posedge clk_i);
		`CHK("word", e, w)
		`CHK("oe off", 1'b0, sdo_oe)
		`CHK("done clr", 1'b0, done)
		if (cmd == CMD_RD_DATA) begin
			`CHK("over", e[0], ovr)
			`CHK("osc", e[1], oscf)
		end
	endtask
	task automatic restart();
		set_in(18'h00010, 1'b0, 1'b0, 1'b0);
		h.frame(1'b1);
		h.xfer(CMD_CONT, 1'b0, w);
		repeat (CONV + 200) @(posedge clk_i);
		`CHK("no cont", 1'b0, done)
		h.xfer(CMD_SINGLE, 1'b0, w);
		h.xfer(CMD_SINGLE, 1'b0, w);
		repeat (CONV - 100) @(posedge clk_i);
		`CHK("restart", 1'b0, done)
		wait_for(1'b0, 1'b1, 300);
		h.xfer(CMD_RD_DATA, 1'b1, w);
		h.frame(1'b0);
		`CHK("rs word", 24'h0010F0, w)
	endtask
	task automatic flag_single();
		set_in(18'h00ABC, 1'b0, 1'b1, 1'b1);
		h.frame(1'b1);
		h.xfer(CMD_SINGLE, 1'b0, w);
		`CHK("flag idle", 1'b1, line)
		wait_for(1'b1, 1'b0, CONV + 300);
		h.xfer(CMD_NULL, 1'b1, w);
		`CHK("fl word", 24'h0ABCF2, w)
		repeat (8) @(posedge clk_i);
		`CHK("flag clr", 1'b1, line)
		h.frame(1'b0);
	endtask
	task automatic cont();
		set_in(18'h00100, 1'b0, 1'b0, 1'b1);
		h.frame(1'b1);
		h.xfer(CMD_CONT, 1'b0, w);
		h.xfer(CMD_CONT, 1'b0, w);
		repeat (CONV - 100) @(posedge clk_i);
		`CHK("cont rst", 1'b1, line)
		wait_for(1'b1, 1'b0, 300);
		set_in(18'h00200, 1'b0, 1'b0, 1'b1);
		wait_for(1'b1, 1'b1, CONV + 100);
		wait_for(1'b1, 1'b0, 5);
		h.xfer(CMD_NULL, 1'b1, w);
		`CHK("cont word", 24'h0200F0, w)
		h.xfer(CMD_RD_CFG, 1'b1, w);
		repeat (CONV + 300) @(posedge clk_i);
		`CHK("cont exit", 1'b1, line)
		h.frame(1'b0);
	endtask
	initial begin
		clk_i = 1'b0;
		rstn_i = 1'b0;
		pfm = 1'b0;
		uni = 1'b0;
		osc = 1'b0;
		raw = 18'h00000;
		err_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		restart();
		conv_read(18'h01234, 1'b0, 1'b0, CMD_RD_DATA, 24'h1234F0);
		conv_read(18'h3FFFF, 1'b0, 1'b0, CMD_RD_DATA, 24'hFFFFF0);
		conv_read(18'h363C0, 1'b0, 1'b0, CMD_RD_DATA, 24'h8000F1);
		conv_read(18'h11170, 1'b1, 1'b1, CMD_RD_DATA, 24'hFFFFF3);
		conv_read(18'h3FFFB, 1'b1, 1'b0, CMD_RD_DATA, 24'h0000F1);
		conv_read(18'h00064, 1'b1, 1'b0, CMD_RD_DATA, 24'h0064F0);
		conv_read(18'h00064, 1'b1, 1'b0, CMD_RD_OFFS, WORD_ZERO);
		conv_read(18'h00064, 1'b1, 1'b0, CMD_RD_GAIN, WORD_ZERO);
		flag_single();
		cont();
		results();
	end
endmodule
